//--- src/pcrc_defines.vh
`ifndef PCRC_DEFINES_VH
`define PCRC_DEFINES_VH

// register byte addresses
`define PCRC_ADDR_CTRL      4'h0
`define PCRC_ADDR_TAP       4'h4
`define PCRC_ADDR_RESULT    4'h8
`define PCRC_ADDR_WDATA     4'hc

// control_status_reg fields
`define PCRC_POLY_LENGTH_LSB       0
`define PCRC_POLY_LENGTH_MSB       3
`define PCRC_GO_BIT         4
`define PCRC_EMPTY_BIT      6
`define PCRC_FULL_BIT       7
`define PCRC_COUNT_LSB      8
`define PCRC_COUNT_MSB      12
`define PCRC_IDLESTOP_BIT   13

// fifo depths and the length threshold that picks one
`define PCRC_DEPTH_LONG     5'h08
`define PCRC_DEPTH_SHORT    5'h10
`define PCRC_POLY_LENGTH_SPLIT     4'h7

// reset values
`define PCRC_RST_POLY_LENGTH       4'h0
`define PCRC_RST_TAP        15'h0000
`define PCRC_RST_CRC        16'h0000
`define PCRC_RST_COUNT      5'h00

// axi responses
`define PCRC_RESP_OKAY      2'h0
`define PCRC_RESP_SLVERR    2'h2

`endif

//--- src/pcrc_generator.v
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pcrc_defines.vh"

// How it works
// - taps come from tap mask bits 15..1
// - constant and top terms always fed back
// - length field is length minus one, word width
// - fifo 8 deep above length field 7, else 16
// - writing word's top byte bumps count
// - shift only while go and count nonzero
// - bit zero done decrements count, continue
// - one bit shifted per clock
// - full at depth, empty at zero
// - write while full rolls count to zero
// - interrupt on count going one to zero
// - count may show one cycle after write
// - sleep freezes state, resumes later
// - idle stop acts like sleep, events pass
// - reset clears controls, count, full; empty set
// - clearing go halts the shifter
module pcrc_generator
(
    input  wire        clk,
    input  wire        clkEn,
    input  wire        reset_n,
    input  wire        sleepReq,
    input  wire        idleReq,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         crcIrq
);

////////////////////////////////////////////////////////////////////////////
// state

reg  [1:0]  sleepSync_q;
reg  [1:0]  idleSync_q;
reg         awHeld_q;
reg  [3:0]  awAddr_q;
reg         awBad_q;
reg         wHeld_q;
reg  [31:0] wData_q;
reg  [3:0]  wStrb_q;
reg  [3:0]  poly_length_q;
reg         shift_go_q;
reg         idle_stop_q;
reg  [15:1] tap_mask_q;
reg  [15:0] crc_q;
reg  [15:0] stage_q;
reg  [4:0]  fifo_word_count_q;
reg  [3:0]  wrPtr_q;
reg  [3:0]  rdPtr_q;
reg  [3:0]  bitIdx_q;
reg         midWord_q;
reg  [15:0] fifoMem [0:15];

////////////////////////////////////////////////////////////////////////////
// derived terms

wire        longPoly = poly_length_q > `PCRC_POLY_LENGTH_SPLIT;
wire [4:0]  depth = longPoly ? `PCRC_DEPTH_LONG
                             : `PCRC_DEPTH_SHORT;
wire        fifo_full_flag = fifo_word_count_q == depth;
wire        fifo_empty_flag = fifo_word_count_q == 5'h00;
// sleep or idle-with-stop suspend the engine and fifo pushes; bus stays served
wire        engineRun = ~sleepSync_q[1]
                        & ~(idleSync_q[1] & idle_stop_q);
wire        doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
// writes outside the decoded window are answered but never land
wire        goodWrite = doWrite & ~awBad_q;
wire        wrCtrl = goodWrite & (awAddr_q == `PCRC_ADDR_CTRL);
wire        wrTap = goodWrite & (awAddr_q == `PCRC_ADDR_TAP);
wire        wrResult = goodWrite & (awAddr_q == `PCRC_ADDR_RESULT);
wire        wrData = goodWrite & (awAddr_q == `PCRC_ADDR_WDATA);
wire        wrMapped = wrCtrl | wrTap | wrResult | wrData;
// unmapped reads select no register, so the default arm returns zero
wire [3:0]  rdSel = (s_axi_araddr[31:4] != 28'h0) ? 4'h1
                                                 : {s_axi_araddr[3:2], 2'h0};
// the word's top byte lane follows the programmed length
wire        msbLane = longPoly ? wStrb_q[1] : wStrb_q[0];
wire [15:0] mergedWord = {wStrb_q[1] ? wData_q[15:8] : stage_q[15:8],
                          wStrb_q[0] ? wData_q[7:0] : stage_q[7:0]};
wire        push = wrData & msbLane & engineRun;
wire        overflow = push & fifo_full_flag;
wire        shiftEn = engineRun & shift_go_q
                      & ~fifo_empty_flag;
wire [3:0]  curIdx = midWord_q ? bitIdx_q : poly_length_q;
wire [15:0] curWord = fifoMem[rdPtr_q];
wire        dataBit = curWord[curIdx];
wire        pop = shiftEn & (curIdx == 4'h0) & ~overflow;

////////////////////////////////////////////////////////////////////////////
// crc step: msb-first lfsr, width set by the length field

reg  [15:0] widthMask;
reg  [15:0] crcStep;
reg         feedback;
integer     i;
always @*
begin
    widthMask = 16'h0000;
    for (i = 0; i < 16; i = i + 1)
    begin
        widthMask[i] = (i <= poly_length_q);
    end
    feedback = dataBit ^ crc_q[poly_length_q];
    // top term implied by dropping the shifted-out bit
    crcStep = {crc_q[14:0], 1'b0} & widthMask;
    if (feedback)
    begin
        crcStep = crcStep
                  ^ ({tap_mask_q, 1'b1} & widthMask);
    end
end

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

always @(posedge clk)
begin
    if (!reset_n)
    begin
        sleepSync_q <= 2'h0;
        idleSync_q  <= 2'h0;
    end
    else if (clkEn)
    begin
        sleepSync_q <= {sleepSync_q[0], sleepReq};
        idleSync_q  <= {idleSync_q[0], idleReq};
    end
end

////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel: address and data taken in either order

always @(posedge clk)
begin
    if (!reset_n)
    begin
        awHeld_q      <= 1'b0;
        awAddr_q      <= 4'h0;
        awBad_q       <= 1'b0;
        wHeld_q       <= 1'b0;
        wData_q       <= 32'h00000000;
        wStrb_q       <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `PCRC_RESP_OKAY;
    end
    else if (clkEn)
    begin
        s_axi_awready <= ~awHeld_q & ~(s_axi_awvalid & s_axi_awready);
        s_axi_wready  <= ~wHeld_q & ~(s_axi_wvalid & s_axi_wready);
        if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[3:2], 2'h0};
            awBad_q  <= (s_axi_awaddr[31:4] != 28'h0);
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end
        if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMapped ? `PCRC_RESP_OKAY
                                     : `PCRC_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel

always @(posedge clk)
begin
    if (!reset_n)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `PCRC_RESP_OKAY;
    end
    else if (clkEn)
    begin
        s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= (s_axi_araddr[31:4] == 28'h0)
                            ? `PCRC_RESP_OKAY : `PCRC_RESP_SLVERR;
            case (rdSel)
                `PCRC_ADDR_CTRL:
                    s_axi_rdata <= {18'h0, idle_stop_q, fifo_word_count_q,
                                    fifo_full_flag, fifo_empty_flag, 1'b0,
                                    shift_go_q, poly_length_q};
                `PCRC_ADDR_TAP:
                    s_axi_rdata <= {16'h0, tap_mask_q, 1'b0};
                `PCRC_ADDR_RESULT:
                    s_axi_rdata <= {16'h0, crc_q};
                default:
                    s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// control, tap mask and staging registers

always @(posedge clk)
begin
    if (!reset_n)
    begin
        poly_length_q <= `PCRC_RST_POLY_LENGTH;
        shift_go_q    <= 1'b0;
        idle_stop_q   <= 1'b0;
        tap_mask_q    <= `PCRC_RST_TAP;
        stage_q       <= 16'h0000;
    end
    else if (clkEn)
    begin
        if (wrCtrl && wStrb_q[0])
        begin
            poly_length_q <= wData_q[`PCRC_POLY_LENGTH_MSB:`PCRC_POLY_LENGTH_LSB];
            shift_go_q    <= wData_q[`PCRC_GO_BIT];
        end
        if (wrCtrl && wStrb_q[1])
        begin
            idle_stop_q <= wData_q[`PCRC_IDLESTOP_BIT];
        end
        if (wrTap && wStrb_q[0])
        begin
            tap_mask_q[7:1] <= wData_q[7:1];
        end
        if (wrTap && wStrb_q[1])
        begin
            tap_mask_q[15:8] <= wData_q[15:8];
        end
        // partial lower byte of a long word waits here for its top byte
        if (wrData)
        begin
            stage_q <= mergedWord;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// fifo, word count and serial shifter

always @(posedge clk)
begin
    if (clkEn && push)
    begin
        fifoMem[wrPtr_q] <= mergedWord;
    end
end

always @(posedge clk)
begin
    if (!reset_n)
    begin
        fifo_word_count_q <= `PCRC_RST_COUNT;
        wrPtr_q           <= 4'h0;
        rdPtr_q           <= 4'h0;
        bitIdx_q          <= 4'h0;
        midWord_q         <= 1'b0;
        crc_q             <= `PCRC_RST_CRC;
        crcIrq            <= 1'b0;
    end
    else if (clkEn)
    begin
        // pulse lands in the cycle after the last pop, even if the
        // engine is then suspended
        crcIrq <= pop & ~push
                  & (fifo_word_count_q == 5'h01);
        if (overflow)
        begin
            // stale words are discarded and no event is raised
            fifo_word_count_q <= 5'h00;
            wrPtr_q           <= 4'h0;
            rdPtr_q           <= 4'h0;
            midWord_q         <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= wrPtr_q + 4'h1;
            end
            if (pop)
            begin
                rdPtr_q <= rdPtr_q + 4'h1;
            end
            if (push && !pop)
            begin
                fifo_word_count_q <= fifo_word_count_q + 5'h01;
            end
            else if (pop && !push)
            begin
                fifo_word_count_q <= fifo_word_count_q - 5'h01;
            end
        end
        if (wrResult)
        begin
            crc_q <= wData_q[15:0];
        end
        else if (shiftEn && !overflow)
        begin
            crc_q <= crcStep;
            if (curIdx == 4'h0)
            begin
                midWord_q <= 1'b0;
            end
            else
            begin
                bitIdx_q  <= curIdx - 4'h1;
                midWord_q <= 1'b1;
            end
        end
    end
end

endmodule // pcrc_generator

//--- bench/pcrc_checker.sv
`timescale 1ns/1ps
`include "pcrc_defines.vh"
module pcrc_checker
(
    input wire        clk,
    input wire        reset_n,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        crcIrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire arTaken = s_axi_arvalid && s_axi_arready;
    wire badAddr = s_axi_araddr[31:4] != 28'h0;
    ////////////////////////////////////////////////////////////////////////
    AST_IRQ_PULSE: assert property (crcIrq |=> !crcIrq)
        else $error("interrupt longer than one cycle");
    AST_FLAGS: assert property (arTaken && !badAddr &&
        s_axi_araddr[3:0] == `PCRC_ADDR_CTRL |=> s_axi_rvalid &&
        s_axi_rdata[7] == (s_axi_rdata[12:8] ==
        (s_axi_rdata[3:0] > 4'h7 ? 5'h08 : 5'h10)) &&
        s_axi_rdata[6] == (s_axi_rdata[12:8] == 5'h00))
        else $error("full or empty flag disagrees with count");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_R_SLVERR: assert property (arTaken && badAddr |=>
        s_axi_rvalid && s_axi_rresp == `PCRC_RESP_SLVERR)
        else $error("unmapped read not refused");
    AST_R_OKAY: assert property (arTaken && !badAddr |=>
        s_axi_rvalid && s_axi_rresp == `PCRC_RESP_OKAY)
        else $error("mapped read refused");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    AST_B_RISE: assert property ($rose(s_axi_bvalid) |->
        !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write answered before both channels held");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && !s_axi_awready)
        else $error("write response not retired");
endmodule // pcrc_checker
bind pcrc_generator pcrc_checker chk (.clk, .reset_n, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .crcIrq);

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "pcrc_defines.vh"
module testbench;
    logic        clk = 0, clkEn = 1, reset_n = 0, sleepReq = 0, idleReq = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, rd;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid, crcIrq;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    logic [1:0]  rsp;
    int          miscompares = 0, checks = 0, irqCount = 0;

    always #50 clk = ~clk;
    always @(posedge clk) if (crcIrq === 1'b1) irqCount <= irqCount + 1;

    pcrc_generator dut
    (
        .clk, .clkEn, .reset_n, .sleepReq, .idleReq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .crcIrq
    );
    ////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // both channels offered together, each released at its own handshake
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end
        while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
        rsp = s_axi_bresp;
    endtask

    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        chk(rd, exp);
    endtask

    // reference shifter, msb first, top term falls out of the mask
    function automatic logic [31:0] crcStep(input logic [15:0] c,
        input logic [3:0] p, input logic [15:0] tap, input logic [15:0] w);
        logic [16:0] m;
        logic        fb;
        m = (17'h1 << (p + 1)) - 17'h1;
        for (int i = p; i >= 0; i--)
        begin
            fb = w[i] ^ c[p];
            c = ((c << 1) ^ (fb ? (tap | 16'h1) : 16'h0)) & m[15:0];
        end
        return {16'h0, c};
    endfunction

    // bounded so a dead shifter cannot hang the run
    task waitIrq;
        int n;
        n = 0;
        while (crcIrq !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        chk(n < 300, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdchk(`PCRC_ADDR_CTRL, 32'h40);
        rdchk(`PCRC_ADDR_TAP, 32'h0);
        rdchk(`PCRC_ADDR_RESULT, 32'h0);
        rdchk(32'h10, 32'h0);
        chk(rsp, `PCRC_RESP_SLVERR);
        wr(32'h10, 32'h1f, 4'h3);
        chk(rsp, `PCRC_RESP_SLVERR);
        rdchk(`PCRC_ADDR_CTRL, 32'h40);
        wr(`PCRC_ADDR_TAP, 32'hffff, 4'hf);
        chk(rsp, `PCRC_RESP_OKAY);
        rdchk(`PCRC_ADDR_TAP, 32'hfffe);
        $display("test reset done");
    endtask

    task t_crc;
        wr(`PCRC_ADDR_CTRL, 32'h0f, 4'h3);
        wr(`PCRC_ADDR_TAP, 32'h1020, 4'h3);
        wr(`PCRC_ADDR_WDATA, 32'h1234, 4'h3);
        wr(`PCRC_ADDR_WDATA, 32'hab, 4'h1);
        wr(`PCRC_ADDR_WDATA, 32'hcd00, 4'h2);
        rdchk(`PCRC_ADDR_CTRL, 32'h020f);
        wr(`PCRC_ADDR_CTRL, 32'h1f, 4'h3);
        waitIrq;
        rdchk(`PCRC_ADDR_CTRL, 32'h5f);
        rdchk(`PCRC_ADDR_RESULT, crcStep(crcStep(0, 15, 16'h1020, 16'h1234),
            15, 16'h1020, 16'hcdab));
        $display("test crc done");
    endtask

    task t_fill;
        int base;
        base = irqCount;
        // the shifter must be off, or it drains words while they are written
        wr(`PCRC_ADDR_CTRL, 32'h0f, 4'h1);
        for (int i = 0; i < 8; i++) wr(`PCRC_ADDR_WDATA, i, 4'h3);
        rdchk(`PCRC_ADDR_CTRL, 32'h088f);
        wr(`PCRC_ADDR_WDATA, 32'h55, 4'h3);
        rdchk(`PCRC_ADDR_CTRL, 32'h4f);
        wr(`PCRC_ADDR_CTRL, 32'h07, 4'h1);
        for (int i = 0; i < 16; i++) wr(`PCRC_ADDR_WDATA, i, 4'h1);
        rdchk(`PCRC_ADDR_CTRL, 32'h1087);
        wr(`PCRC_ADDR_WDATA, 32'h55, 4'h1);
        rdchk(`PCRC_ADDR_CTRL, 32'h47);
        chk(irqCount, base);
        $display("test fill done");
    endtask

    // fixed waits only prove that nothing moves while held
    task t_suspend;
        wr(`PCRC_ADDR_RESULT, 32'h0, 4'h3);
        wr(`PCRC_ADDR_WDATA, 32'h5a, 4'h1);
        wr(`PCRC_ADDR_WDATA, 32'hc3, 4'h1);
        sleepReq <= 1;
        wr(`PCRC_ADDR_CTRL, 32'h2017, 4'h3);
        repeat (30) @(posedge clk);
        rdchk(`PCRC_ADDR_CTRL, 32'h2217);
        idleReq <= 1;
        sleepReq <= 0;
        repeat (30) @(posedge clk);
        rdchk(`PCRC_ADDR_CTRL, 32'h2217);
        wr(`PCRC_ADDR_CTRL, 32'h07, 4'h3);
        repeat (30) @(posedge clk);
        rdchk(`PCRC_ADDR_CTRL, 32'h0207);
        wr(`PCRC_ADDR_CTRL, 32'h17, 4'h3);
        // clock enable low must hold the shifter mid-word
        clkEn <= 0;
        repeat (40) @(posedge clk);
        clkEn <= 1;
        rdchk(`PCRC_ADDR_CTRL, 32'h0217);
        waitIrq;
        rdchk(`PCRC_ADDR_CTRL, 32'h57);
        rdchk(`PCRC_ADDR_RESULT, crcStep(crcStep(0, 7, 16'h1020, 16'h5a),
            7, 16'h1020, 16'hc3));
        $display("test suspend done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        t_reset;
        t_crc;
        t_fill;
        t_suspend;
        results;
    end

    initial
    begin
        #2_000_000;
        miscompares++;
        results;
    end
endmodule // testbench
